// >>> cwd_top.sv
// Purpose: complementary waveform generator with dead band
// Assumes: data_in is on sys_clk; shutdown pins and osc are async
// Notes:   all outputs are registered
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`include "cwd_consts.svh"
module cwd_top #(
	parameter int DB_W = `CWD_DB_W,
	parameter int NSRC = `CWD_NSRC
) (
	// clock and reset
	input  wire logic            sys_clk_in,
	input  wire logic            rst_b_in,
	// register port
	input  wire logic [3:0]      reg_addr_in,
	input  wire logic [7:0]      reg_wdata_in,
	input  wire logic            reg_wr_in,
	input  wire logic            reg_rd_in,
	output logic      [7:0]      reg_rdata_out,
	// waveform source and timing
	input  wire logic            data_in,
	input  wire logic            internal_fast_oscillator_in,
	input  wire logic            sleep_in,
	// shutdown sources, active low
	input  wire logic [NSRC-1:0] shutdown_src_b_in,
	// driver outputs
	output logic                 output_a_out,
	output logic                 output_b_out,
	output logic                 output_c_out,
	output logic                 output_d_out,
	output logic                 shutdown_event_flag_out
);
	// ==========================================================
	// register state
	logic            en_ff;
	logic            ld_ff;
	logic            ld_arm_ff;
	logic [2:0]      mode_ff;
	logic [3:0]      pol_ff;
	logic            cs_ff;
	logic [DB_W-1:0] rise_buf_ff;
	logic [DB_W-1:0] fall_buf_ff;
	logic [DB_W-1:0] rise_act_ff;
	logic [DB_W-1:0] fall_act_ff;
	logic [3:0]      str_ff;
	logic [3:0]      ovr_ff;
	logic [3:0]      str_act_ff;
	logic            ren_ff;
	logic [1:0]      override_level_pair_two_ff;
	logic [1:0]      override_level_pair_one_ff;
	logic [NSRC-1:0] src_en_ff;
	logic            flag_ff;

	// ==========================================================
	// waveform state
	cwd_pkg::cwd_sd_state_e sd_state_ff;
	cwd_pkg::cwd_sd_state_e nxt_sd_state;
	logic            d_prev_ff;
	logic            osc_prev_ff;
	logic            a_on_ff;
	logic            b_on_ff;
	logic            dir_ff;
	logic            mod_en_ff;
	logic            seq_ff;
	logic [3:0]      nxt_out;

	// ==========================================================
	// combinational helpers
	logic            wr_ctrl;
	logic            wr_pol;
	logic            wr_clk;
	logic            wr_dbr;
	logic            wr_dbf;
	logic            wr_steer;
	logic            wr_asd0;
	logic            wr_asd1;
	logic            wr_flag;
	logic            sw_set;
	logic            sw_clr;
	logic            d_rise;
	logic            d_fall;
	logic            osc_q;
	logic            tick;
	logic [NSRC-1:0] src_q;
	logic            cond;
	logic            go;
	logic            is_half;
	logic            is_full;
	logic            is_pp;
	logic            is_steer;
	logic            dir_chg;
	logic [1:0]      db_start;
	logic [1:0]      db_abort;
	logic [1:0]      db_fire;
	logic [3:0]      act;
	logic [3:0]      ovl;

	// ==========================================================
	// write decode
	assign wr_ctrl  = reg_wr_in && (reg_addr_in == `CWD_REG_CTRL);
	assign wr_pol   = reg_wr_in && (reg_addr_in == `CWD_REG_POL);
	assign wr_clk   = reg_wr_in && (reg_addr_in == `CWD_REG_CLK);
	assign wr_dbr   = reg_wr_in && (reg_addr_in == `CWD_REG_DBR);
	assign wr_dbf   = reg_wr_in && (reg_addr_in == `CWD_REG_DBF);
	assign wr_steer = reg_wr_in && (reg_addr_in == `CWD_REG_STEER);
	assign wr_asd0  = reg_wr_in && (reg_addr_in == `CWD_REG_ASD0);
	assign wr_asd1  = reg_wr_in && (reg_addr_in == `CWD_REG_ASD1);
	assign wr_flag  = reg_wr_in && (reg_addr_in == `CWD_REG_FLAG);
	assign sw_set   = wr_asd0 && reg_wdata_in[`CWD_ASD0_SD];
	assign sw_clr   = wr_asd0 && !reg_wdata_in[`CWD_ASD0_SD];

	// ==========================================================
	// pins from outside the clock domain
	cwd_sync #(.W(1)) u_osc_sync (
		.sys_clk_in (sys_clk_in),
		.rst_b_in   (rst_b_in),
		.sig_in     (internal_fast_oscillator_in),
		.q_out      (osc_q)
	);

	cwd_sync #(.W(NSRC)) u_src_sync (
		.sys_clk_in (sys_clk_in),
		.rst_b_in   (rst_b_in),
		.sig_in     (shutdown_src_b_in),
		.q_out      (src_q)
	);

	// ==========================================================
	// edge history of data and oscillator
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			d_prev_ff   <= 1'b0;
			osc_prev_ff <= 1'b1;
		end else begin
			d_prev_ff   <= data_in;
			osc_prev_ff <= osc_q;
		end
	end

	assign d_rise = data_in && !d_prev_ff;
	assign d_fall = !data_in && d_prev_ff;
	// system clock stops in sleep, so no ticks on that source
	assign tick   = cs_ff ? (osc_q && !osc_prev_ff) : !sleep_in;

	// ==========================================================
	// mode decode
	assign is_half  = (mode_ff == `CWD_MODE_HALF);
	assign is_pp    = (mode_ff == `CWD_MODE_PP);
	assign is_full  = (mode_ff == `CWD_MODE_FFWD) ||
		(mode_ff == `CWD_MODE_FREV);
	assign is_steer = (mode_ff == `CWD_MODE_ASTEER) ||
		(mode_ff == `CWD_MODE_SSTEER);
	assign dir_chg  = (mode_ff[0] != dir_ff);

	// ==========================================================
	// control register and load request
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			en_ff     <= 1'b0;
			mode_ff   <= 3'h0;
			ld_ff     <= 1'b0;
			ld_arm_ff <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				en_ff   <= reg_wdata_in[`CWD_CTRL_EN];
				mode_ff <= reg_wdata_in[2:0];
			end
			// request only honoured once already enabled
			if (!en_ff) begin
				ld_ff     <= 1'b0;
				ld_arm_ff <= 1'b0;
			end else if (ld_arm_ff && d_rise) begin
				ld_ff     <= 1'b0;
				ld_arm_ff <= 1'b0;
			end else begin
				if (wr_ctrl && reg_wdata_in[`CWD_CTRL_LD]) begin
					ld_ff <= 1'b1;
				end
				if (ld_ff && d_fall) begin
					ld_arm_ff <= 1'b1;
				end
			end
		end
	end

	// ==========================================================
	// dead-band count buffers
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rise_buf_ff <= `CWD_RST_DB;
			fall_buf_ff <= `CWD_RST_DB;
			rise_act_ff <= `CWD_RST_DB;
			fall_act_ff <= `CWD_RST_DB;
		end else begin
			if (wr_dbr) begin
				rise_buf_ff <= reg_wdata_in[DB_W-1:0];
			end
			if (wr_dbf) begin
				fall_buf_ff <= reg_wdata_in[DB_W-1:0];
			end
			if (!en_ff) begin
				// disabled: a write reaches the active copy at once
				if (wr_dbr) begin
					rise_act_ff <= reg_wdata_in[DB_W-1:0];
				end
				if (wr_dbf) begin
					fall_act_ff <= reg_wdata_in[DB_W-1:0];
				end
			end else if (ld_arm_ff && d_rise) begin
				rise_act_ff <= rise_buf_ff;
				fall_act_ff <= fall_buf_ff;
			end
		end
	end

	// ==========================================================
	// output and clock configuration
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pol_ff    <= 4'h0;
			cs_ff     <= 1'b0;
			str_ff    <= 4'h0;
			ovr_ff    <= 4'h0;
			ren_ff    <= 1'b0;
			override_level_pair_two_ff   <= 2'h0;
			override_level_pair_one_ff   <= 2'h0;
			src_en_ff <= '0;
		end else begin
			if (wr_pol) begin
				pol_ff <= reg_wdata_in[3:0];
			end
			if (wr_clk) begin
				cs_ff <= reg_wdata_in[0];
			end
			if (wr_steer) begin
				ovr_ff <= reg_wdata_in[7:4];
				str_ff <= reg_wdata_in[3:0];
			end
			if (wr_asd0) begin
				ren_ff  <= reg_wdata_in[`CWD_ASD0_REN];
				override_level_pair_two_ff <= reg_wdata_in[5:4];
				override_level_pair_one_ff <= reg_wdata_in[3:2];
			end
			if (wr_asd1) begin
				src_en_ff <= reg_wdata_in[NSRC-1:0];
			end
		end
	end

	// ==========================================================
	// shutdown sequencer; clearing an enable drops its source
	assign cond = |(src_en_ff & ~src_q);

	always_comb begin
		nxt_sd_state = sd_state_ff;
		case (sd_state_ff)
			cwd_pkg::CWD_SD_RUN: begin
				if (sw_set || cond) begin
					nxt_sd_state = cwd_pkg::CWD_SD_HOLD;
				end
			end
			cwd_pkg::CWD_SD_HOLD: begin
				// a clear while a source is active is ignored
				if (!cond && (ren_ff || sw_clr)) begin
					nxt_sd_state = cwd_pkg::CWD_SD_WAIT;
				end
			end
			cwd_pkg::CWD_SD_WAIT: begin
				if (sw_set || cond) begin
					nxt_sd_state = cwd_pkg::CWD_SD_HOLD;
				end else if (d_rise) begin
					nxt_sd_state = cwd_pkg::CWD_SD_RUN;
				end
			end
			default: begin
				nxt_sd_state = cwd_pkg::CWD_SD_HOLD;
			end
		endcase
	end

	// start-up is from the shutdown state
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sd_state_ff <= cwd_pkg::CWD_SD_HOLD;
		end else begin
			sd_state_ff <= nxt_sd_state;
		end
	end

	// event flag; a set beats a clear in the same cycle
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			flag_ff <= 1'b0;
		end else if ((nxt_sd_state == cwd_pkg::CWD_SD_HOLD) &&
			(sd_state_ff != cwd_pkg::CWD_SD_HOLD)) begin
			flag_ff <= 1'b1;
		end else if (wr_flag && reg_wdata_in[0]) begin
			flag_ff <= 1'b0;
		end
	end

	// edges are processed this cycle, including the resuming edge
	assign go = en_ff && (nxt_sd_state == cwd_pkg::CWD_SD_RUN);

	// ==========================================================
	// dead-band counter starts and aborts
	always_comb begin
		db_start = 2'b00;
		db_abort = 2'b00;
		if (go && is_half) begin
			db_start[0] = d_rise && (rise_act_ff != '0);
			db_start[1] = d_fall && (fall_act_ff != '0);
			db_abort[0] = d_fall;
			db_abort[1] = d_rise;
		end else if (go && is_full) begin
			db_start[0] = d_rise && dir_chg && mode_ff[0] &&
				(rise_act_ff != '0);
			db_start[1] = d_rise && dir_chg && !mode_ff[0] &&
				(fall_act_ff != '0);
			db_abort    = {d_fall, d_fall};
		end else begin
			db_abort = 2'b11;
		end
	end

	// ==========================================================
	// the two counters: index 0 rise/reverse, 1 fall/forward
	for (genvar i = 0; i < 2; i++) begin : g_db
		cwd_db_if #(.W(DB_W)) dbif ();
		assign dbif.start = db_start[i];
		assign dbif.abort = db_abort[i];
		assign dbif.tick  = tick;
		assign dbif.value = (i == 0) ? rise_act_ff : fall_act_ff;
		assign db_fire[i] = dbif.fire;

		cwd_deadband #(.W(DB_W)) u_db (
			.sys_clk_in (sys_clk_in),
			.rst_b_in   (rst_b_in),
			.db         (dbif.unit)
		);
	end

	// ==========================================================
	// half bridge: each turn-on waits for its own dead band
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			a_on_ff <= 1'b0;
			b_on_ff <= 1'b0;
		end else if (!go || !is_half) begin
			a_on_ff <= 1'b0;
			b_on_ff <= 1'b0;
		end else begin
			if (d_fall) begin
				a_on_ff <= 1'b0;
			end else if ((d_rise && (rise_act_ff == '0)) ||
				db_fire[0]) begin
				a_on_ff <= 1'b1;
			end
			if (d_rise) begin
				b_on_ff <= 1'b0;
			end else if ((d_fall && (fall_act_ff == '0)) ||
				db_fire[1]) begin
				b_on_ff <= 1'b1;
			end
		end
	end

	// ==========================================================
	// full bridge direction, taken at a rising data edge
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			dir_ff    <= 1'b0;
			mod_en_ff <= 1'b1;
		end else if (!go || !is_full) begin
			dir_ff    <= mode_ff[0];
			mod_en_ff <= 1'b1;
		end else if (d_rise && dir_chg) begin
			dir_ff    <= mode_ff[0];
			mod_en_ff <= mode_ff[0] ? (rise_act_ff == '0) :
				(fall_act_ff == '0);
		end else if (|db_fire || d_fall) begin
			// a cut-short pulse stays dark; the next one runs
			mod_en_ff <= 1'b1;
		end
	end

	// ==========================================================
	// push-pull sequencer, restarted by disable or shutdown
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			seq_ff <= 1'b0;
		end else if (!go || !is_pp) begin
			seq_ff <= 1'b0;
		end else if (d_fall) begin
			seq_ff <= !seq_ff;
		end
	end

	// synchronous steering picks up selection at a rising edge
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			str_act_ff <= 4'h0;
		end else if (mode_ff != `CWD_MODE_SSTEER) begin
			str_act_ff <= str_ff;
		end else if (d_rise) begin
			str_act_ff <= str_ff;
		end
	end

	// ==========================================================
	// output composition: active sense first, then polarity, overrides last
	assign ovl = {override_level_pair_two_ff[1], override_level_pair_one_ff[1], override_level_pair_two_ff[0], override_level_pair_one_ff[0]};

	always_comb begin
		act = 4'h0;
		if (is_half) begin
			act = {b_on_ff, a_on_ff, b_on_ff, a_on_ff};
		end else if (is_pp) begin
			act = {data_in && seq_ff, data_in && !seq_ff,
				data_in && seq_ff, data_in && !seq_ff};
		end else if (is_full) begin
			act[0] = !dir_ff;
			act[2] = dir_ff;
			act[1] = dir_ff && data_in && mod_en_ff;
			act[3] = !dir_ff && data_in && mod_en_ff;
		end else begin
			act = {4{data_in}};
		end
		for (int k = 0; k < 4; k++) begin
			nxt_out[k] = pol_ff[k] ? act[k] : !act[k];
		end
		if (is_steer) begin
			for (int k = 0; k < 4; k++) begin
				// async steering reads the selection straight away
				if (!((mode_ff == `CWD_MODE_ASTEER) ? str_ff[k] :
					str_act_ff[k])) begin
					nxt_out[k] = ovr_ff[k];
				end else if (!go) begin
					nxt_out[k] = ovl[k];
				end
			end
		end else if (en_ff && !go) begin
			nxt_out = ovl;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			output_a_out <= 1'b0;
			output_b_out <= 1'b0;
			output_c_out <= 1'b0;
			output_d_out <= 1'b0;
		end else begin
			output_a_out <= nxt_out[0];
			output_b_out <= nxt_out[1];
			output_c_out <= nxt_out[2];
			output_d_out <= nxt_out[3];
		end
	end

	assign shutdown_event_flag_out = flag_ff;

	// ==========================================================
	// read port; unmapped indices and idle cycles read zero
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			reg_rdata_out <= `CWD_RST_BYTE;
		end else if (!reg_rd_in) begin
			reg_rdata_out <= `CWD_RST_BYTE;
		end else begin
			case (reg_addr_in)
				`CWD_REG_CTRL:  reg_rdata_out <= {en_ff, ld_ff, 3'h0,
					mode_ff};
				`CWD_REG_POL:   reg_rdata_out <= {2'h0, data_in, 1'b0,
					pol_ff};
				`CWD_REG_CLK:   reg_rdata_out <= {7'h00, cs_ff};
				`CWD_REG_DBR:   reg_rdata_out <= {2'h0, rise_buf_ff};
				`CWD_REG_DBF:   reg_rdata_out <= {2'h0, fall_buf_ff};
				`CWD_REG_STEER: reg_rdata_out <= {ovr_ff, str_ff};
				`CWD_REG_ASD0:  reg_rdata_out <= {
					sd_state_ff == cwd_pkg::CWD_SD_HOLD, ren_ff,
					override_level_pair_two_ff, override_level_pair_one_ff, 2'h0};
				`CWD_REG_ASD1:  reg_rdata_out <= {~src_q, src_en_ff};
				`CWD_REG_FLAG:  reg_rdata_out <= {7'h00, flag_ff};
				default:        reg_rdata_out <= `CWD_RST_BYTE;
			endcase
		end
	end
endmodule : cwd_top

// >>> cwd_consts.svh
// Purpose: shared constants of the complementary waveform dead-band block
// Assumes: 4-bit register index, 8-bit register data
// Notes:   offsets, field positions, reset values and mode codes
//
// Behaviour
// - async steering change applies right after write
// - one bit picks dead-band clock source
// - per-output polarity bit, set means active-high
// - polarity never touches override or steering
// - two 6-bit counters, rise/reverse and fall/forward
// - dead band counts ticks from zero upward
// - half bridge delays A on rise, B on fall
// - full bridge A/C switch at once, modulated delayed
// - reverse band on B only, forward on D
// - each interval programmable over full counter range
// - zero count means no delay at all
// - early return of input cancels that pulse
// - counts double-buffered, load request when enabled
// - async edges add at most one tick
// - software shutdown bit forces and holds shutdown
// - enabled active-low sources force override immediately
// - sources level sensitive, hold shutdown while active
// - one field drives B/D, other A/C
// - entering shutdown sets the event flag
// - software clears shutdown, resume on rising edge
// - auto-restart clears shutdown when sources gone
// - software clear ignored while condition present
`ifndef CWD_CONSTS_SVH
`define CWD_CONSTS_SVH

// ==========================================================
// register indices
`define CWD_REG_CTRL   4'h0
`define CWD_REG_POL    4'h1
`define CWD_REG_CLK    4'h2
`define CWD_REG_DBR    4'h3
`define CWD_REG_DBF    4'h4
`define CWD_REG_STEER  4'h5
`define CWD_REG_ASD0   4'h6
`define CWD_REG_ASD1   4'h7
`define CWD_REG_FLAG   4'h8

// ==========================================================
// field positions
`define CWD_CTRL_EN    7
`define CWD_CTRL_LD    6
`define CWD_ASD0_SD    7
`define CWD_ASD0_REN   6

// ==========================================================
// mode codes
`define CWD_MODE_ASTEER 3'h0
`define CWD_MODE_SSTEER 3'h1
`define CWD_MODE_FFWD   3'h2
`define CWD_MODE_FREV   3'h3
`define CWD_MODE_HALF   3'h4
`define CWD_MODE_PP     3'h5

// ==========================================================
// widths and reset values
`define CWD_DB_W       6
`define CWD_NSRC       4
`define CWD_RST_BYTE   8'h00
`define CWD_RST_DB     6'h00

`endif

// >>> cwd_pkg.sv
// Purpose: types of the waveform dead-band block
// Assumes: nothing
// Notes:   shutdown sequencer states
package cwd_pkg;
	// ==========================================================
	// shutdown sequencer
	typedef enum logic [1:0] {
		CWD_SD_RUN,
		CWD_SD_HOLD,
		CWD_SD_WAIT
	} cwd_sd_state_e;

	typedef logic [5:0] cwd_cnt_t;
endpackage : cwd_pkg

// >>> cwd_db_if.sv
// Purpose: link between the top and one dead-band counter
// Assumes: single clock
// Notes:   fire is a one-cycle pulse
`timescale 1ns/10ps
interface cwd_db_if #(parameter int W = 6);
	logic         start;
	logic         abort;
	logic         tick;
	logic [W-1:0] value;
	logic         fire;

	modport ctrl (output start, output abort, output tick,
		output value, input fire);
	modport unit (input start, input abort, input tick,
		input value, output fire);
endinterface : cwd_db_if

// >>> cwd_sync.sv
// Purpose: three-stage synchroniser with agreement filter
// Assumes: asynchronous inputs
// Notes:   output moves only when stages two and three agree
`timescale 1ns/10ps
module cwd_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         sys_clk_in,
	input  wire logic         rst_b_in,
	// signals
	input  wire logic [W-1:0] sig_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;

	// ==========================================================
	// stage one is read only by stage two
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s1_ff <= '1;
			s2_ff <= '1;
			s3_ff <= '1;
			q_out <= '1;
		end else begin
			s1_ff <= sig_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			// per-bit agreement filter
			q_out <= (s2_ff & s3_ff) | (q_out & (s2_ff | s3_ff));
		end
	end
endmodule : cwd_sync

// >>> cwd_deadband.sv
// Purpose: one dead-band interval counter
// Assumes: tick marks one dead-band clock period
// Notes:   fire pulses once the programmed count has elapsed
`timescale 1ns/10ps
module cwd_deadband #(
	parameter int W = 6
) (
	// clock and reset
	input  wire logic sys_clk_in,
	input  wire logic rst_b_in,
	// control link
	cwd_db_if.unit    db
);
	logic         busy_ff;
	logic [W-1:0] cnt_ff;
	logic         fire_ff;
	logic [W:0]   cnt_inc;

	assign cnt_inc = {1'b0, cnt_ff} + {{W{1'b0}}, 1'b1};
	assign db.fire = fire_ff;

	// ==========================================================
	// count from zero up to the value; an abort cancels the pulse
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			busy_ff <= 1'b0;
			cnt_ff  <= '0;
			fire_ff <= 1'b0;
		end else begin
			fire_ff <= 1'b0;
			if (db.abort) begin
				busy_ff <= 1'b0;
			end else if (db.start) begin
				busy_ff <= 1'b1;
				cnt_ff  <= '0;
			end else if (busy_ff && db.tick) begin
				// edge lands mid-period, so one tick of jitter
				if (cnt_inc >= {1'b0, db.value}) begin
					busy_ff <= 1'b0;
					fire_ff <= 1'b1;
				end else begin
					cnt_ff <= cnt_inc[W-1:0];
				end
			end
		end
	end
endmodule : cwd_deadband

// >>> cwd_top_assertions.sv
// Purpose: port checks of the waveform dead-band block
// Assumes: shadows follow port writes
// Notes:   shutdown checks only in half bridge, after writes settle except the SD readback
`timescale 1ns/10ps
module cwd_top_assertions #(
	parameter int DB_W = 6,
	parameter int NSRC = 4
) (
	// clock and reset
	input wire logic            sys_clk_in,
	input wire logic            rst_b_in,
	// register port
	input wire logic [3:0]      reg_addr_in,
	input wire logic [7:0]      reg_wdata_in,
	input wire logic            reg_wr_in,
	input wire logic            reg_rd_in,
	input wire logic [7:0]      reg_rdata_out,
	// sources and outputs
	input wire logic [NSRC-1:0] shutdown_src_b_in,
	input wire logic            output_a_out,
	input wire logic            output_b_out,
	input wire logic            output_c_out,
	input wire logic            output_d_out,
	input wire logic            shutdown_event_flag_out
);
	// ====
	// shadows; the quiet count hides write transients
	logic [3:0] ctl_ff, pol_ff, ena_ff, lvl_ff;
	logic [2:0] wq_ff;
	logic       hold, hs;
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			{ctl_ff, pol_ff, ena_ff, lvl_ff} <= 16'h0000;
			wq_ff <= 3'h0;
		end else begin
			wq_ff <= reg_wr_in ? 3'h0 : wq_ff + {2'h0, wq_ff != 3'h7};
			if (reg_wr_in && reg_addr_in == 4'h0)
				ctl_ff <= {reg_wdata_in[7], reg_wdata_in[2:0]};
			if (reg_wr_in && reg_addr_in == 4'h1)
				pol_ff <= reg_wdata_in[3:0];
			if (reg_wr_in && reg_addr_in == 4'h6)
				lvl_ff <= {reg_wdata_in[5], reg_wdata_in[4:2]};
			if (reg_wr_in && reg_addr_in == 4'h7)
				ena_ff <= reg_wdata_in[3:0];
		end
	end
	assign hold = ctl_ff == 4'hC && |(~shutdown_src_b_in & ena_ff);
	assign hs   = hold && wq_ff == 3'h7;
	// ====
	// properties
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);
	property p_rd_idle;
		!$past(reg_rd_in) |-> reg_rdata_out == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
	property p_pol_rd;
		reg_rd_in && reg_addr_in == 4'h1 |=> reg_rdata_out[3:0] == pol_ff;
	endproperty
	a_pol_rd: assert property (p_pol_rd) else $error("pol readback");
	property p_ovr_ac;
		hs[*8] |-> output_a_out == lvl_ff[0] && output_c_out == lvl_ff[1];
	endproperty
	a_ovr_ac: assert property (p_ovr_ac) else $error("a/c override");
	property p_ovr_bd;
		hs[*8] |-> output_b_out == lvl_ff[2] && output_d_out == lvl_ff[3];
	endproperty
	a_ovr_bd: assert property (p_ovr_bd) else $error("b/d override");
	property p_flag;
		hs[*8] |-> shutdown_event_flag_out;
	endproperty
	a_flag: assert property (p_flag) else $error("flag not set");
	property p_hold;
		hs[*8] ##1 hs |-> $stable({output_a_out, output_b_out});
	endproperty
	a_hold: assert property (p_hold) else $error("outputs moved");
	property p_sd_bit;
		hold[*8] ##0 (reg_rd_in && reg_addr_in == 4'h6) |=> reg_rdata_out[7];
	endproperty
	a_sd_bit: assert property (p_sd_bit) else $error("shutdown lost");
	property p_gap;
		ctl_ff == 4'hC && pol_ff[1:0] == 2'h3 && !(lvl_ff[0] && lvl_ff[2])
			&& wq_ff == 3'h7 |-> !(output_a_out && output_b_out);
	endproperty
	a_gap: assert property (p_gap) else $error("a and b overlap");
	c_hold: cover property (hs[*8]);
	c_a_on: cover property (ctl_ff == 4'hC && output_a_out && !output_b_out);
	c_read: cover property (reg_rdata_out != 8'h00);
endmodule : cwd_top_assertions

bind cwd_top cwd_top_assertions #(.DB_W(DB_W), .NSRC(NSRC))
	i_cwd_top_assertions (.sys_clk_in, .rst_b_in, .reg_addr_in,
	.reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
	.shutdown_src_b_in, .output_a_out, .output_b_out, .output_c_out,
	.output_d_out, .shutdown_event_flag_out);

// >>> cwd_src_model.sv
// Purpose: on-chip pulse source and free fast oscillator
// Assumes: data changes right after a clock edge
// Notes:   oscillator phase unrelated to the system clock
`timescale 1ns/10ps
module cwd_src_model (
	// clock
	input  wire logic clk_in,
	// source outputs
	output logic      data_out,
	output logic      osc_out
);
	// ====
	// oscillator runs free, rate arbitrary
	initial begin
		data_out = 1'b0;
		osc_out  = 1'b0;
		forever #60.3 osc_out = ~osc_out;
	end
	// one level change after an edge
	task automatic set_data(input logic v);
		@(posedge clk_in);
		data_out <= v;
	endtask : set_data
endmodule : cwd_src_model

// >>> cwd_top_tb_top.sv
// Purpose: register-level tests of the waveform dead-band block
// Assumes: 40 MHz clock, tasks speak the plain register port
// Notes:   lags counted in edges, one tick of jitter allowed
`timescale 1ns/10ps
module cwd_top_tb_top;
	logic       sys_clk_in, rst_b_in, wr_s, rd_s, dat, osc, slp;
	logic       oa, ob, oc, od, flg;
	logic [3:0] addr, src_b;
	logic [7:0] wdat, rdat;
	int         bad_count, num_checks, n;
	logic [7:0] n_db [4] = '{8'h00, 8'h02, 8'h05, 8'h3F};
	cwd_src_model i_cwd_src_model (.clk_in(sys_clk_in), .data_out(dat),
		.osc_out(osc));
	cwd_top i_cwd_top (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
		.reg_addr_in(addr), .reg_wdata_in(wdat), .reg_wr_in(wr_s),
		.reg_rd_in(rd_s), .reg_rdata_out(rdat), .data_in(dat),
		.internal_fast_oscillator_in(osc), .sleep_in(slp),
		.shutdown_src_b_in(src_b), .output_a_out(oa), .output_b_out(ob),
		.output_c_out(oc), .output_d_out(od),
		.shutdown_event_flag_out(flg));
	// ====
	// clock and watchdog
	initial begin
		sys_clk_in = 1'b0;
		forever #12.5 sys_clk_in = ~sys_clk_in;
	end
	initial begin
		#1000000;
		bad_count++;
		wrap_up();
	end
	// ====
	// tasks
	task automatic chk(input string nm, input logic [7:0] e, g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk_in);
		{addr, wdat, wr_s} <= {a, d, 1'b1};
		@(posedge sys_clk_in);
		wr_s <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge sys_clk_in);
		{addr, rd_s} <= {a, 1'b1};
		@(posedge sys_clk_in);
		rd_s <= 1'b0;
		#1 chk("rdata", e, rdat);
	endtask : rd
	// edges until a (w=0) or b (w=1) turns on after data moves
	task automatic lag(input logic v, w);
		i_cwd_src_model.set_data(v);
		#1 n = 0;
		while ((w ? ob : oa) !== 1'b1 && n < 400) begin
			@(posedge sys_clk_in);
			#1 n++;
		end
	endtask : lag
	// count plus register stages, with one tick of jitter
	task automatic span(input int d);
		chk("lag", 8'h01, {7'h00, n >= d + 1 && n <= d + 4});
	endtask : span
	task automatic pins(input logic [7:0] e);
		#1 chk("pins", e, {4'h0, od, oc, ob, oa});
	endtask : pins
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up
	// ====
	// main sequence
	initial begin
		{rst_b_in, slp, addr, wdat, wr_s, rd_s, src_b} = 20'h0000F;
		repeat (3) @(posedge sys_clk_in);
		rst_b_in <= 1'b1;
		rd(4'h6, 8'h80);
		rd(4'h9, 8'h00);
		wr(4'h1, 8'h0F);
		rd(4'h1, 8'h0F);
		wr(4'h6, 8'h08);
		foreach (n_db[i]) begin
			wr(4'h0, 8'h04);
			wr(4'h3, n_db[i]);
			wr(4'h4, n_db[i]);
			wr(4'h0, 8'h84);
			lag(1'b1, 1'b0);
			span(n_db[i]);
			lag(1'b0, 1'b1);
			span(n_db[i]);
		end
		// short pulse against a count of 63
		i_cwd_src_model.set_data(1'b1);
		repeat (20) @(posedge sys_clk_in);
		i_cwd_src_model.set_data(1'b0);
		repeat (80) @(posedge sys_clk_in);
		pins(8'h0A);
		wr(4'h3, 8'h02);
		lag(1'b1, 1'b0);
		span(63);
		wr(4'h0, 8'hC4);
		repeat (2) begin
			lag(1'b0, 1'b1);
			lag(1'b1, 1'b0);
		end
		span(2);
		wr(4'h2, 8'h01);
		slp <= 1'b1;
		lag(1'b0, 1'b1);
		lag(1'b1, 1'b0);
		chk("osc", 8'h01, {7'h00, n > 6 && n < 30});
		wr(4'h2, 8'h00);
		slp <= 1'b0;
		wr(4'h7, 8'h01);
		src_b <= 4'hE;
		repeat (16) @(posedge sys_clk_in);
		pins(8'h04);
		chk("flag", 8'h01, {7'h00, flg});
		wr(4'h6, 8'h08);
		rd(4'h6, 8'h88);
		rd(4'h7, 8'h11);
		wr(4'h1, 8'h00);
		pins(8'h04);
		wr(4'h1, 8'h0F);
		src_b <= 4'hF;
		repeat (8) @(posedge sys_clk_in);
		wr(4'h6, 8'h08);
		rd(4'h6, 8'h08);
		i_cwd_src_model.set_data(1'b0);
		pins(8'h04);
		lag(1'b1, 1'b0);
		span(2);
		wr(4'h8, 8'h01);
		rd(4'h8, 8'h00);
		wr(4'h6, 8'h48);
		src_b <= 4'hE;
		repeat (16) @(posedge sys_clk_in);
		src_b <= 4'hF;
		repeat (12) @(posedge sys_clk_in);
		rd(4'h6, 8'h48);
		i_cwd_src_model.set_data(1'b0);
		lag(1'b1, 1'b0);
		span(2);
		wr(4'h6, 8'h88);
		repeat (6) @(posedge sys_clk_in);
		rd(4'h6, 8'h88);
		pins(8'h04);
		wr(4'h6, 8'h08);
		wr(4'h0, 8'h00);
		wr(4'h5, 8'h01);
		wr(4'h0, 8'h80);
		i_cwd_src_model.set_data(1'b0);
		lag(1'b1, 1'b0);
		wr(4'h5, 8'h00);
		repeat (2) @(posedge sys_clk_in);
		pins(8'h00);
		wrap_up();
	end
endmodule : cwd_top_tb_top
